// file: adc_scan_defines.svh
`ifndef ADC_SCAN_DEFINES_SVH
`define ADC_SCAN_DEFINES_SVH
`define CLK_FREQ_HZ 200000000
`define TIMER_FREQ_HZ 1000000
`define TIMER_DIV_CYCLES (`CLK_FREQ_HZ / `TIMER_FREQ_HZ)
`define TIMER_DIV_W 8
`define INTERVAL_W 16
`define INTERVAL_RESET 16'h0014
`define CHAN_W 4
`define CHAN_ZERO 4'h0
`define RESULT_W 16
`define FIFO_DEPTH 256
`define FIFO_AW 8
`define BUF_DEPTH 32
`define BUF_AW 5
`define STATUS_W 2
`define STATUS_AVAIL_BIT 0
`define STATUS_OVF_BIT 1
`endif

// file: adc_scan_pkg.sv
package adc_scan_pkg;
    // Scan direction as held in the second command register
    typedef enum logic {
        SCAN_DOWN = 1'b0,
        SCAN_UP = 1'b1
    } scan_dir_t;
    // Pacing source state: idle, armed by timer, conversion pending
    typedef enum logic [1:0] {
        PACE_IDLE = 2'b00,
        PACE_ARMED = 2'b01,
        PACE_FIRE = 2'b11
    } pace_state_t;
endpackage

// file: adc_scan_fifo_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_scan_defines.svh"

// Synchronous FIFO, valid and ready on both sides.
// Depth must be a power of two so the pointers wrap on their own.
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Honest full and empty from the occupancy count
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage written only, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap naturally; depth must be a power of two
    always_ff @(posedge clk) begin
        if (srst || flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            end
            if (push && !pop) begin
                count_reg <= count_reg + (AW+1)'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - (AW+1)'(1);
            end
        end
    end
endmodule

// Acquisition control: pacing, channel sequencing, result store, flags.
// Results are taken without back-pressure; result_ready is advisory only,
// so a converter that ignores it still sees the overflow flag on a loss.
module adc_scan_fifo_control (
    input wire logic clk,
    input wire logic srst,
    input wire logic [`CHAN_W-1:0] channel_select,
    input wire logic scan_enable_n,
    input wire logic fifo_irq_enable,
    input wire adc_scan_pkg::scan_dir_t scan_direction,
    input wire logic timer_enable,
    input wire logic [`INTERVAL_W-1:0] sample_interval,
    input wire logic ext_convert_strobe_n,
    output logic sample_timer_output,
    output logic convert_start,
    output logic [`CHAN_W-1:0] convert_channel,
    input wire logic [`RESULT_W-1:0] result_data,
    input wire logic result_valid,
    output logic result_ready,
    input wire logic acq_clear,
    input wire logic fifo_read,
    output logic [`RESULT_W-1:0] fifo_data,
    output logic [`STATUS_W-1:0] status,
    output logic irq
);
    import adc_scan_pkg::*;

    logic [`TIMER_DIV_W-1:0] tick_div_reg;
    logic sample_timer_clock;
    logic [`INTERVAL_W-1:0] interval_cnt_reg;
    logic timer_out_reg;
    logic timer_out_d_reg;
    logic strobe_d_reg;
    logic scan_en_n_d_reg;
    logic conv_evt;
    logic timer_rise;
    logic strobe_rise;
    logic scan_load;
    logic [`CHAN_W-1:0] chan_reg;
    logic [`CHAN_W-1:0] chan_next;
    logic ovf_reg;
    logic [`RESULT_W-1:0] buf_data;
    logic buf_valid;
    logic buf_ready;
    logic [`RESULT_W-1:0] res_data;
    logic res_valid;
    logic res_in_ready;
    logic res_out_valid;
    logic [`RESULT_W-1:0] res_out_data;
    logic irq_arm_reg;
    logic irq_reg;
    logic drop_evt;
    logic store_evt;
    logic pop_evt;
    logic [`RESULT_W-1:0] fifo_data_reg;
    logic convert_start_reg;
    logic result_ready_reg;

    // Next channel of the scan, wraps at either end
    function automatic logic [`CHAN_W-1:0] step_chan(
        input logic [`CHAN_W-1:0] cur,
        input logic [`CHAN_W-1:0] top,
        input scan_dir_t dir
    );
        logic [`CHAN_W-1:0] nxt;
        nxt = cur;
        if (dir == SCAN_UP) begin
            nxt = (cur >= top) ? `CHAN_ZERO : cur + `CHAN_W'(1);
        end else begin
            nxt = (cur == `CHAN_ZERO || cur > top) ? top : cur - `CHAN_W'(1);
        end
        return nxt;
    endfunction

    // Rising edge from the live level and the last cycle's level
    function automatic logic rose_now(
        input logic cur,
        input logic prev
    );
        return cur && !prev;
    endfunction

    // 1 MHz tick from system clock
    always_ff @(posedge clk) begin
        if (srst || tick_div_reg == `TIMER_DIV_W'(`TIMER_DIV_CYCLES - 1)) begin
            tick_div_reg <= '0;
        end else begin
            tick_div_reg <= tick_div_reg + `TIMER_DIV_W'(1);
        end
    end
    assign sample_timer_clock = (tick_div_reg == `TIMER_DIV_W'(`TIMER_DIV_CYCLES - 1));

    // Rate-generator behaviour: output low for one tick every N ticks.
    // Disabled timer holds the output high, arming the external strobe.
    // Interval is taken at each reload; a change lands in the next period.
    always_ff @(posedge clk) begin
        if (srst || !timer_enable) begin
            interval_cnt_reg <= sample_interval;
            timer_out_reg <= 1'b1;
        end else if (sample_timer_clock) begin
            if (interval_cnt_reg <= `INTERVAL_W'(1)) begin
                interval_cnt_reg <= sample_interval;
                timer_out_reg <= 1'b1;
            end else begin
                interval_cnt_reg <= interval_cnt_reg - `INTERVAL_W'(1);
                timer_out_reg <= (interval_cnt_reg != `INTERVAL_W'(2));
            end
        end
    end

    // Edge detect history for timer, strobe and scan enable
    always_ff @(posedge clk) begin
        if (srst) begin
            timer_out_d_reg <= 1'b1;
            strobe_d_reg <= 1'b1;
            scan_en_n_d_reg <= 1'b1;
        end else begin
            timer_out_d_reg <= timer_out_reg;
            strobe_d_reg <= ext_convert_strobe_n;
            scan_en_n_d_reg <= scan_enable_n;
        end
    end

    // Edge events; strobe and scan enable rest high after reset
    assign timer_rise = rose_now(timer_out_reg, timer_out_d_reg);
    assign strobe_rise = rose_now(ext_convert_strobe_n, strobe_d_reg);
    assign scan_load = rose_now(!scan_enable_n, !scan_en_n_d_reg);

    // Strobe gated by the timer level, so a low output refuses it
    // Either pacing source starts a conversion
    assign conv_evt = timer_rise || (timer_out_reg && strobe_rise);

    always_comb begin
        chan_next = chan_reg;
        if (scan_enable_n) begin
            chan_next = channel_select;
        end else if (scan_load) begin
            chan_next = (scan_direction == SCAN_UP) ? `CHAN_ZERO : channel_select;
        end else if (conv_evt) begin
            chan_next = step_chan(chan_reg, channel_select, scan_direction);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            chan_reg <= `CHAN_ZERO;
        end else begin
            chan_reg <= chan_next;
        end
    end

    // Start pulse carries the channel converted before stepping
    // A start in the scan load cycle is dropped; chan_reg still holds the single-mode channel
    always_ff @(posedge clk) begin
        if (srst) begin
            convert_start_reg <= 1'b0;
            convert_channel <= `CHAN_ZERO;
        end else begin
            convert_start_reg <= conv_evt && !scan_load;
            if (conv_evt) begin
                convert_channel <= scan_enable_n ? channel_select : chan_reg;
            end
        end
    end
    assign convert_start = convert_start_reg;

    // Results pass a small elastic buffer, drained every cycle so it never fills
    result_fifo #(
        .WIDTH(`RESULT_W),
        .DEPTH(`BUF_DEPTH),
        .AW(`BUF_AW)
    ) u_in_buf (
        .clk(clk),
        .srst(srst),
        .flush(1'b0),
        .in_data(result_data),
        .in_valid(result_valid),
        .in_ready(buf_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(1'b1)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            result_ready_reg <= 1'b0;
        end else begin
            result_ready_reg <= buf_ready;
        end
    end
    assign result_ready = result_ready_reg;

    // Full result store drops the incoming result
    assign res_data = buf_data;
    assign res_valid = buf_valid;

    result_fifo #(
        .WIDTH(`RESULT_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_result_fifo (
        .clk(clk),
        .srst(srst),
        .flush(1'b0),
        .in_data(res_data),
        .in_valid(res_valid),
        .in_ready(res_in_ready),
        .out_data(res_out_data),
        .out_valid(res_out_valid),
        .out_ready(fifo_read)
    );

    // Store-side events shared by the flag logic
    assign drop_evt = res_valid && !res_in_ready;
    assign store_evt = res_valid && res_in_ready;
    assign pop_evt = fifo_read && res_out_valid;

    // Clear leaves stored results in place; only reading empties the store
    // Overflow sticky; a new loss wins over a clear
    always_ff @(posedge clk) begin
        if (srst) begin
            ovf_reg <= 1'b0;
        end else if (drop_evt) begin
            ovf_reg <= 1'b1;
        end else if (acq_clear) begin
            ovf_reg <= 1'b0;
        end
    end

    // Both flags in one status word
    always_ff @(posedge clk) begin
        if (srst) begin
            status <= '0;
        end else begin
            status[`STATUS_AVAIL_BIT] <= res_out_valid;
            status[`STATUS_OVF_BIT] <= ovf_reg || drop_evt;
        end
    end

    // Read data registered; head word captured on each read strobe that finds data
    always_ff @(posedge clk) begin
        if (srst) begin
            fifo_data_reg <= '0;
        end else begin
            if (pop_evt) begin
                fifo_data_reg <= res_out_data;
            end
        end
    end
    assign fifo_data = fifo_data_reg;

    // Clear drops a pending request until data arrives anew
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_arm_reg <= 1'b1;
        end else if (store_evt) begin
            irq_arm_reg <= 1'b1;
        end else if (acq_clear) begin
            irq_arm_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= fifo_irq_enable && res_out_valid && irq_arm_reg && !acq_clear;
        end
    end
    assign irq = irq_reg;
    assign sample_timer_output = timer_out_reg;
endmodule

`default_nettype wire

// file: adc_scan_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_scan_defines.svh"
module adc_scan_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic [`CHAN_W-1:0] channel_select,
    input wire logic scan_enable_n,
    input wire logic fifo_irq_enable,
    input wire adc_scan_pkg::scan_dir_t scan_direction,
    input wire logic ext_convert_strobe_n,
    input wire logic sample_timer_output,
    input wire logic convert_start,
    input wire logic [`CHAN_W-1:0] convert_channel,
    input wire logic acq_clear,
    input wire logic [`STATUS_W-1:0] status,
    input wire logic irq
);
    import adc_scan_pkg::*;
    logic [`CHAN_W-1:0] last_reg;
    logic have_reg;
    // Previous scan channel, forgotten in single mode
    always_ff @(posedge clk) begin
        if (srst || scan_enable_n) begin
            have_reg <= 1'b0;
        end else if (convert_start) begin
            have_reg <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (convert_start) begin
            last_reg <= convert_channel;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_armed;
        $rose(ext_convert_strobe_n) && sample_timer_output;
    endsequence
    sequence s_blocked;
        $rose(ext_convert_strobe_n) && !sample_timer_output;
    endsequence
    sequence s_timer_rise;
        $rose(sample_timer_output);
    endsequence
    // Pacing sources
    a_strobe_start: assert property (s_armed |=> convert_start)
        else $error("strobe edge gave no start");
    a_strobe_block: assert property (s_blocked |=> !convert_start)
        else $error("strobe edge started with timer low");
    a_timer_start: assert property (s_timer_rise |=> convert_start)
        else $error("timer rise gave no start");
    a_start_pulse: assert property (convert_start |=> !convert_start)
        else $error("start longer than one cycle");
    // Channel choice; stepping checked against the last start
    a_single_chan: assert property (convert_start && scan_enable_n |-> convert_channel == channel_select)
        else $error("single mode channel wrong");
    a_scan_down: assert property (convert_start && have_reg && scan_direction == SCAN_DOWN
        |-> convert_channel == (last_reg == `CHAN_ZERO ? channel_select : last_reg - 4'h1))
        else $error("down scan step wrong");
    a_scan_up: assert property (convert_start && have_reg && scan_direction == SCAN_UP
        |-> convert_channel == (last_reg == channel_select ? `CHAN_ZERO : last_reg + 4'h1))
        else $error("up scan step wrong");
    // Interrupt and overflow; two cycles allow for the status register
    a_irq_off: assert property (!fifo_irq_enable [*2] |-> !irq)
        else $error("irq while disabled");
    a_irq_clear: assert property (acq_clear |=> !irq)
        else $error("irq survived clear");
    a_ovf_clear: assert property (acq_clear |-> ##2 !status[`STATUS_OVF_BIT])
        else $error("overflow survived clear");
endmodule
bind adc_scan_fifo_control adc_scan_chk u_chk (
    .clk(clk), .srst(srst), .channel_select(channel_select), .scan_enable_n(scan_enable_n),
    .fifo_irq_enable(fifo_irq_enable), .scan_direction(scan_direction),
    .ext_convert_strobe_n(ext_convert_strobe_n), .sample_timer_output(sample_timer_output),
    .convert_start(convert_start), .convert_channel(convert_channel), .acq_clear(acq_clear),
    .status(status), .irq(irq)
);
`default_nettype wire

// file: adc_scan_fifo_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_scan_defines.svh"
module adc_scan_fifo_control_tb;
    import adc_scan_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] channel_select = 4'h0;
    logic [3:0] t;
    logic [3:0] convert_channel;
    logic scan_enable_n = 1'b1, fifo_irq_enable = 1'b0, timer_enable = 1'b0;
    logic ext_convert_strobe_n = 1'b1, result_valid = 1'b0, acq_clear = 1'b0, fifo_read = 1'b0;
    logic sample_timer_output, convert_start, result_ready, irq, rd_seen;
    logic [15:0] sample_interval = 16'h0002;
    logic [15:0] result_data = 16'h0000;
    logic [15:0] lfsr = 16'hBAE4;
    logic [15:0] fifo_data;
    logic [1:0] status;
    scan_dir_t scan_direction = SCAN_DOWN;
    int error_cnt = 0, samples_checked = 0, n, m;
    logic [15:0] chan_q[$];
    logic [15:0] data_q[$];
    initial begin
        forever #2.5 clk = ~clk;
    end
    adc_scan_fifo_control DUT (
        .clk(clk), .srst(srst), .channel_select(channel_select), .scan_enable_n(scan_enable_n),
        .fifo_irq_enable(fifo_irq_enable), .scan_direction(scan_direction), .timer_enable(timer_enable),
        .sample_interval(sample_interval), .ext_convert_strobe_n(ext_convert_strobe_n),
        .sample_timer_output(sample_timer_output), .convert_start(convert_start),
        .convert_channel(convert_channel), .result_data(result_data), .result_valid(result_valid),
        .result_ready(result_ready), .acq_clear(acq_clear), .fifo_read(fifo_read),
        .fifo_data(fifo_data), .status(status), .irq(irq)
    );
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [15:0] next_rand(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // Strobe pulse; note the channel only when a start should follow
    task automatic strobe(input logic [3:0] ch, input logic take);
        ext_convert_strobe_n = 1'b0;
        cyc(1);
        ext_convert_strobe_n = 1'b1;
        if (take) chan_q.push_back({12'h000, ch});
        cyc(3);
    endtask
    // Back-to-back results; only the first note words are expected back
    task automatic burst(input int cnt, input int note);
        result_valid = 1'b1;
        for (int i = 0; i < cnt; i++) begin
            result_data = lfsr;
            lfsr = next_rand(lfsr);
            if (i < note) data_q.push_back(result_data);
            cyc(1);
        end
        result_valid = 1'b0;
        cyc(8);
    endtask
    task automatic drain();
        n = 0;
        while (status[0] === 1'b1 && n < 400) begin
            fifo_read = 1'b1;
            cyc(1);
            fifo_read = 1'b0;
            cyc(2);
            n++;
        end
    endtask
    task automatic clear();
        acq_clear = 1'b1;
        cyc(1);
        acq_clear = 1'b0;
        cyc(3);
    endtask
    task automatic wait_lvl(input logic v);
        m = 0;
        while (sample_timer_output !== v && m < 3000) begin
            cyc(1);
            m++;
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Scoreboard: oldest note against each start or popped word
    always @(posedge clk) begin
        rd_seen = fifo_read;
        #1;
        if (convert_start === 1'b1) begin
            if (chan_q.size() == 0) check("extra start", 16'h0001, 16'h0000);
            else check("channel", {12'h000, convert_channel}, chan_q.pop_front());
        end
        if (rd_seen === 1'b1 && data_q.size() > 0) check("fifo_data", fifo_data, data_q.pop_front());
    end
    initial begin
        cyc(60000);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        cyc(16);
        srst = 1'b0;
        cyc(2);
        check("ready idle", {15'h0000, result_ready}, 16'h0001);
        check("status idle", {14'h0000, status}, 16'h0000);
        // Scans both ways, tops 1, 15 and random; direction before channel, enable set then cleared
        for (int d = 0; d < 2; d++) begin
            for (int k = 0; k < 3; k++) begin
                t = k == 0 ? 4'h1 : k == 1 ? 4'hF : 4'(lfsr % 15 + 1);
                lfsr = next_rand(lfsr);
                scan_direction = scan_dir_t'(d);
                channel_select = t;
                scan_enable_n = 1'b1;
                cyc(2);
                scan_enable_n = 1'b0;
                cyc(4);
                for (int i = 0; i < t + 3; i++) strobe(d ? 4'(i % (t + 1)) : 4'(t - i % (t + 1)), 1'b1);
                scan_enable_n = 1'b1;
                cyc(2);
            end
        end
        $display("scan test done");
        for (int k = 0; k < 4; k++) begin
            channel_select = lfsr[3:0];
            lfsr = next_rand(lfsr);
            cyc(2);
            strobe(channel_select, 1'b1);
        end
        $display("single channel test done");
        // Timer pacing; a strobe while the output is low must be refused
        channel_select = 4'h5;
        timer_enable = 1'b1;
        wait_lvl(1'b0);
        strobe(4'h5, 1'b0);
        chan_q.push_back(16'h0005);
        wait_lvl(1'b1);
        n = m + 4;
        check("low span", 16'(n), 16'd200);
        wait_lvl(1'b0);
        check("period", 16'(n + m), 16'd400);
        chan_q.push_back(16'h0005);
        wait_lvl(1'b1);
        cyc(5);
        timer_enable = 1'b0;
        check("notes left", 16'(chan_q.size()), 16'h0000);
        $display("timer test done");
        // Interrupt follows data-available, drops on drain or clear
        fifo_irq_enable = 1'b1;
        burst(3, 3);
        check("status", {14'h0000, status}, 16'h0001);
        check("irq", {15'h0000, irq}, 16'h0001);
        drain();
        check("irq drained", {15'h0000, irq}, 16'h0000);
        check("reads", 16'(n), 16'h0003);
        fifo_irq_enable = 1'b0;
        burst(1, 1);
        check("irq masked", {15'h0000, irq}, 16'h0000);
        fifo_irq_enable = 1'b1;
        cyc(3);
        check("irq unmasked", {15'h0000, irq}, 16'h0001);
        clear();
        check("irq cleared", {15'h0000, irq}, 16'h0000);
        check("kept data", {14'h0000, status}, 16'h0001);
        drain();
        fifo_irq_enable = 1'b0;
        $display("interrupt test done");
        // Exactly full, then one more overflows and is lost
        burst(256, 256);
        check("full status", {14'h0000, status}, 16'h0001);
        burst(1, 0);
        check("ovf status", {14'h0000, status}, 16'h0003);
        drain();
        check("reads", 16'(n), 16'd256);
        check("ovf sticky", {14'h0000, status}, 16'h0002);
        clear();
        check("ovf cleared", {14'h0000, status}, 16'h0000);
        $display("overflow test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
